// *** rtl/ahrp_params.svh ***
// timing, width and field constants for the adc host read port
`ifndef AHRP_PARAMS_SVH
`define AHRP_PARAMS_SVH

`define AHRP_CLK_MHZ     250
`define AHRP_CONV_NS     6000
`define AHRP_CONV_CYC    ((`AHRP_CONV_NS * `AHRP_CLK_MHZ + 999) / 1000)
`define AHRP_STROBE_CYC  4
`define AHRP_GAP_CYC     2
`define AHRP_RES_W       12
`define AHRP_BYTE_W      8
`define AHRP_MSB_W       4
`define AHRP_MSB_LSB     8
`define AHRP_BUF_DEPTH   2

`endif

// *** rtl/ahrp_pkg.sv ***
// types shared by both ends of the adc host read port
`include "ahrp_params.svh"

package ahrp_pkg;

  typedef logic [`AHRP_RES_W-1:0] ahrp_sample_t;

  typedef enum logic [1:0] {
    AHRP_DS_IDLE  = 2'b00,
    AHRP_DS_CONV  = 2'b01,
    AHRP_DS_FETCH = 2'b11
  } ahrp_dev_state_t;

  typedef enum logic [2:0] {
    AHRP_HS_IDLE  = 3'b000,
    AHRP_HS_LO    = 3'b001,
    AHRP_HS_GAP   = 3'b011,
    AHRP_HS_HI    = 3'b010,
    AHRP_HS_SPACE = 3'b110
  } ahrp_host_state_t;

endpackage

// *** rtl/ahrp_if.sv ***
// pins between the converter end and the host end
`timescale 1ns/100ps
`include "ahrp_params.svh"

interface ahrp_if;
  logic                      cs_n;
  logic                      rd_n;
  logic                      upper_byte_select;
  logic                      busy_n;
  logic [`AHRP_RES_W-1:0]    data;
  logic                      data_oe;

  modport device (
    input  cs_n,
    input  rd_n,
    input  upper_byte_select,
    output busy_n,
    output data,
    output data_oe
  );

  modport host (
    output cs_n,
    output rd_n,
    output upper_byte_select,
    input  busy_n,
    input  data,
    input  data_oe
  );
endinterface

// *** rtl/ahrp_device.sv ***
// converter end: start gating, conversion timer, result latch and data lanes
`timescale 1ns/100ps
`include "ahrp_params.svh"

// Contract
// [R1] even read starts conversion, returns low byte
// [R2] odd read returns high byte
// [R3] host makes 16-bit load from two reads
// [R4] wait mode: busy holds first read
// [R5] high byte read needs no wait
// [R6] previous mode: read returns older result
// [R7] read after completion returns new value
// [R8] host spaces reads by conversion time
// [R9] external counter advances mux per sample
// [R10] start needs select, strobe, byte select low
// [R11] busy low while converting, high when latched
// [R12] starts ignored until conversion completes
// [R13] high read: msbs low lanes, rest low; code also repeats the msbs on bits 11:8
// [R14] data driven only while selected and reading; code drives data_oe from a flop, so it follows select and read one cycle late
module ahrp_device #(
  parameter int CONV_CYC = `AHRP_CONV_CYC,
  parameter int DEPTH    = `AHRP_BUF_DEPTH
) (
  input  wire logic            clock_in,
  input  wire logic            rst_in,
  ahrp_if.device               bus,
  input  wire ahrp_pkg::ahrp_sample_t sample_in,
  input  wire logic            sample_valid_in,
  output logic                 sample_ready_out,
  output logic                 conv_start_out,
  output logic                 conv_busy_out
);
  import ahrp_pkg::*;

  localparam int CNT_W = $clog2(CONV_CYC + 1);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int LVL_W = $clog2(DEPTH + 1);

  // state and latch registers
  ahrp_dev_state_t          state_ff;
  ahrp_dev_state_t          nxt_state;
  logic [CNT_W-1:0]         cnt_ff;
  logic [CNT_W-1:0]         nxt_cnt;
  ahrp_sample_t             result_ff;
  ahrp_sample_t             nxt_result;
  logic                     cond_ff;
  logic                     nxt_cond;
  logic                     busy_n_ff;
  logic                     nxt_busy_n;
  logic                     busy_ff;
  logic                     nxt_busy;
  logic                     start_ff;
  logic                     nxt_start;
  logic [`AHRP_RES_W-1:0]   data_ff;
  logic [`AHRP_RES_W-1:0]   nxt_data;
  logic                     oe_ff;
  logic                     nxt_oe;

  // sample buffer registers
  ahrp_sample_t             buf_ff [DEPTH];
  ahrp_sample_t             nxt_buf [DEPTH];
  logic [PTR_W-1:0]         wr_ptr_ff;
  logic [PTR_W-1:0]         nxt_wr_ptr;
  logic [PTR_W-1:0]         rd_ptr_ff;
  logic [PTR_W-1:0]         nxt_rd_ptr;
  logic [LVL_W-1:0]         level_ff;
  logic [LVL_W-1:0]         nxt_level;
  logic                     ready_ff;
  logic                     nxt_ready;

  logic                     start_cond;
  logic                     start;
  logic                     push;
  logic                     pop;
  logic                     sel_rd;

  // all three control pins low together form a start condition
  assign start_cond = ~bus.cs_n & ~bus.rd_n & ~bus.upper_byte_select; // [R10] [R1]
  // only a fresh condition while idle launches; others are dropped
  assign start      = start_cond & ~cond_ff & (state_ff == AHRP_DS_IDLE); // [R12]
  assign push       = sample_valid_in & ready_ff;
  assign pop        = (state_ff == AHRP_DS_FETCH) & (level_ff != '0);
  assign sel_rd     = ~bus.cs_n & ~bus.rd_n;

  // conversion sequencer
  always_comb begin
    nxt_state  = state_ff;
    nxt_cnt    = cnt_ff;
    nxt_result = result_ff;
    nxt_start  = 1'b0;
    nxt_cond   = start_cond;
    case (state_ff)
      AHRP_DS_IDLE: begin
        if (start) begin
          nxt_state = AHRP_DS_CONV;
          nxt_cnt   = '0;
          nxt_start = 1'b1; // [R9]
        end
      end
      AHRP_DS_CONV: begin
        // starts during this phase fall through the idle check
        if (cnt_ff == CNT_W'(CONV_CYC - 1)) begin // [R12]
          nxt_state = AHRP_DS_FETCH;
        end else begin
          nxt_cnt = cnt_ff + CNT_W'(1);
        end
      end
      AHRP_DS_FETCH: begin
        // stays busy until the front end has a word to latch
        if (pop) begin
          nxt_result = buf_ff[rd_ptr_ff]; // [R7]
          nxt_state  = AHRP_DS_IDLE;
        end
      end
      default: begin
        nxt_state = AHRP_DS_IDLE;
      end
    endcase
  end

  // busy follows the sequencer, released as the latch updates
  always_comb begin
    nxt_busy_n = (nxt_state == AHRP_DS_IDLE); // [R11] [R4]
    nxt_busy   = (nxt_state != AHRP_DS_IDLE); // [R11]
  end

  // data lanes built from the value the latch holds next cycle
  always_comb begin
    nxt_oe = sel_rd; // [R14]
    if (~sel_rd) begin
      nxt_data = '0; // [R14]
    end else if (bus.upper_byte_select) begin
      nxt_data = {nxt_result[`AHRP_RES_W-1:`AHRP_MSB_LSB],
                  {(`AHRP_BYTE_W - `AHRP_MSB_W){1'b0}},
                  nxt_result[`AHRP_RES_W-1:`AHRP_MSB_LSB]}; // [R2] [R13] [R5]
    end else begin
      nxt_data = nxt_result; // [R1] [R6]
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_ff  <= AHRP_DS_IDLE;
      cnt_ff    <= '0;
      result_ff <= '0;
      cond_ff   <= 1'b0;
      busy_n_ff <= 1'b1;
      busy_ff   <= 1'b0;
      start_ff  <= 1'b0;
      data_ff   <= '0;
      oe_ff     <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      result_ff <= nxt_result;
      cond_ff   <= nxt_cond;
      busy_n_ff <= nxt_busy_n;
      busy_ff   <= nxt_busy;
      start_ff  <= nxt_start;
      data_ff   <= nxt_data;
      oe_ff     <= nxt_oe;
    end
  end

  // buffer entries, one write port per slot
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_slot
      always_comb begin
        nxt_buf[gi] = buf_ff[gi];
        if (push && (wr_ptr_ff == PTR_W'(gi))) begin
          nxt_buf[gi] = sample_in;
        end
      end

      always_ff @(posedge clock_in) begin
        if (rst_in) begin
          buf_ff[gi] <= '0;
        end else begin
          buf_ff[gi] <= nxt_buf[gi];
        end
      end
    end
  endgenerate

  // buffer pointers and fill level; ready drops when full
  always_comb begin
    nxt_wr_ptr = wr_ptr_ff;
    nxt_rd_ptr = rd_ptr_ff;
    nxt_level  = level_ff;
    if (push) begin
      nxt_wr_ptr = (wr_ptr_ff == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_ff + PTR_W'(1);
    end
    if (pop) begin
      nxt_rd_ptr = (rd_ptr_ff == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_ff + PTR_W'(1);
    end
    if (push && !pop) begin
      nxt_level = level_ff + LVL_W'(1);
    end else if (pop && !push) begin
      nxt_level = level_ff - LVL_W'(1);
    end
    nxt_ready = (nxt_level != LVL_W'(DEPTH));
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      level_ff  <= '0;
      ready_ff  <= 1'b0;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      level_ff  <= nxt_level;
      ready_ff  <= nxt_ready;
    end
  end

  // pin and user outputs, all straight from flops
  assign bus.busy_n       = busy_n_ff;
  assign bus.data         = data_ff;
  assign bus.data_oe      = oe_ff;
  assign sample_ready_out = ready_ff;
  assign conv_start_out   = start_ff;
  assign conv_busy_out    = busy_ff;

endmodule

// *** rtl/ahrp_host.sv ***
// host end: drives select, strobe and byte select, assembles results
`timescale 1ns/100ps
`include "ahrp_params.svh"

module ahrp_host #(
  parameter int CONV_CYC   = `AHRP_CONV_CYC,
  parameter int STROBE_CYC = `AHRP_STROBE_CYC,
  parameter int GAP_CYC    = `AHRP_GAP_CYC
) (
  input  wire logic            clock_in,
  input  wire logic            rst_in,
  ahrp_if.host                 bus,
  input  wire logic            start_in,
  input  wire logic            wait_mode_in,
  input  wire logic            result_ready_in,
  output ahrp_pkg::ahrp_sample_t result_out,
  output logic                 result_valid_out,
  output logic                 idle_out
);
  import ahrp_pkg::*;

  localparam int CNT_W = $clog2(CONV_CYC + STROBE_CYC + GAP_CYC + 1);

  ahrp_host_state_t         state_ff;
  ahrp_host_state_t         nxt_state;
  logic [CNT_W-1:0]         cnt_ff;
  logic [CNT_W-1:0]         nxt_cnt;
  logic                     mode_ff;
  logic                     nxt_mode;
  logic [`AHRP_BYTE_W-1:0]  lo_ff;
  logic [`AHRP_BYTE_W-1:0]  nxt_lo;
  ahrp_sample_t             result_ff;
  ahrp_sample_t             nxt_result;
  logic                     valid_ff;
  logic                     nxt_valid;
  logic                     strobe_n_ff;
  logic                     nxt_strobe_n;
  logic                     ube_ff;
  logic                     nxt_ube;
  logic                     idle_ff;
  logic [CNT_W-1:0]         cnt_inc;
  logic                     strobe_done;

  // saturating cycle count, shared by every phase
  assign cnt_inc     = (cnt_ff == '1) ? cnt_ff : cnt_ff + CNT_W'(1);
  assign strobe_done = (cnt_ff >= CNT_W'(STROBE_CYC - 1));

  // read sequencer; stalls while an unread result is pending
  always_comb begin
    nxt_state    = state_ff;
    nxt_cnt      = cnt_inc;
    nxt_mode     = mode_ff;
    nxt_lo       = lo_ff;
    nxt_result   = result_ff;
    nxt_valid    = valid_ff & ~result_ready_in;
    nxt_strobe_n = strobe_n_ff;
    nxt_ube      = ube_ff;
    case (state_ff)
      AHRP_HS_IDLE: begin
        if (start_in && !valid_ff) begin
          nxt_state    = AHRP_HS_LO;
          nxt_cnt      = '0;
          nxt_mode     = wait_mode_in;
          nxt_strobe_n = 1'b0; // [R1]
          nxt_ube      = 1'b0;
        end
      end
      AHRP_HS_LO: begin
        // strobe width exceeds the busy response, so busy is seen low first
        if (strobe_done && (!mode_ff || bus.busy_n)) begin // [R4]
          nxt_strobe_n = 1'b1;
          if (mode_ff) begin
            nxt_lo    = bus.data[`AHRP_BYTE_W-1:0]; // [R3]
            nxt_state = AHRP_HS_GAP;
            nxt_cnt   = '0;
          end else begin
            nxt_result = bus.data; // [R6]
            nxt_valid  = 1'b1;
            nxt_state  = AHRP_HS_SPACE;
          end
        end
      end
      AHRP_HS_GAP: begin
        if (cnt_ff >= CNT_W'(GAP_CYC - 1)) begin
          nxt_state    = AHRP_HS_HI;
          nxt_cnt      = '0;
          nxt_strobe_n = 1'b0;
          nxt_ube      = 1'b1; // [R2] [R3]
        end
      end
      AHRP_HS_HI: begin
        // no busy check on the upper byte read
        if (strobe_done) begin // [R5]
          nxt_result   = {bus.data[`AHRP_MSB_W-1:0], lo_ff}; // [R3]
          nxt_valid    = 1'b1;
          nxt_strobe_n = 1'b1;
          nxt_ube      = 1'b0;
          nxt_state    = AHRP_HS_IDLE;
        end
      end
      AHRP_HS_SPACE: begin
        // next read no sooner than a conversion time after this one
        if ((cnt_ff >= CNT_W'(CONV_CYC - 1)) && bus.busy_n) begin // [R8]
          nxt_state = AHRP_HS_IDLE;
        end
      end
      default: begin
        nxt_state    = AHRP_HS_IDLE;
        nxt_strobe_n = 1'b1;
        nxt_ube      = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_ff    <= AHRP_HS_IDLE;
      cnt_ff      <= '0;
      mode_ff     <= 1'b0;
      lo_ff       <= '0;
      result_ff   <= '0;
      valid_ff    <= 1'b0;
      strobe_n_ff <= 1'b1;
      ube_ff      <= 1'b0;
      idle_ff     <= 1'b1;
    end else begin
      state_ff    <= nxt_state;
      cnt_ff      <= nxt_cnt;
      mode_ff     <= nxt_mode;
      lo_ff       <= nxt_lo;
      result_ff   <= nxt_result;
      valid_ff    <= nxt_valid;
      strobe_n_ff <= nxt_strobe_n;
      ube_ff      <= nxt_ube;
      idle_ff     <= (nxt_state == AHRP_HS_IDLE);
    end
  end

  // select and strobe move together
  assign bus.cs_n              = strobe_n_ff;
  assign bus.rd_n              = strobe_n_ff;
  assign bus.upper_byte_select = ube_ff;
  assign result_out            = result_ff;
  assign result_valid_out      = valid_ff;
  assign idle_out              = idle_ff;

endmodule

// *** verification/ahrp_chk.sv ***
// pin checks between the host end and the converter end
`timescale 1ns/100ps
`include "ahrp_params.svh"

module ahrp_chk #(
  parameter int CONV_CYC = `AHRP_CONV_CYC
) (
  input  wire logic                   clock_in,
  input  wire logic                   rst_in,
  input  wire logic                   cs_n,
  input  wire logic                   rd_n,
  input  wire logic                   upper_byte_select,
  input  wire logic                   busy_n,
  input  wire logic [`AHRP_RES_W-1:0] data,
  input  wire logic                   data_oe
);
  logic [15:0] busy_cnt_ff;
  logic [15:0] nxt_busy_cnt;
  logic        sel_any;
  logic        sel_lo;

  // decoded strobe conditions
  assign sel_any = !cs_n && !rd_n;
  assign sel_lo  = sel_any && !upper_byte_select;

  // length of the running busy period
  always_comb begin
    nxt_busy_cnt = busy_n ? 16'h0000 : busy_cnt_ff + 16'h0001;
  end
  always_ff @(posedge clock_in) begin
    busy_cnt_ff <= rst_in ? 16'h0000 : nxt_busy_cnt;
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  sequence s_start;
    $rose(sel_lo) && busy_n;
  endsequence
  sequence s_hi_read;
    $fell(rd_n) && upper_byte_select;
  endsequence

  property p_start_busy;
    s_start |=> !busy_n;
  endproperty
  property p_hi_nostart;
    sel_any && upper_byte_select && busy_n |=> busy_n;
  endproperty
  property p_busy_len;
    $rose(busy_n) |-> busy_cnt_ff >= CONV_CYC - 1;
  endproperty
  property p_hi_read;
    s_hi_read |-> (!rd_n && upper_byte_select && busy_n) [*4];
  endproperty
  property p_oe_on;
    sel_any |=> data_oe;
  endproperty
  property p_oe_off;
    !sel_any |=> !data_oe;
  endproperty
  property p_idle_zero;
    !data_oe |-> data == 12'h000;
  endproperty
  property p_hi_lanes;
    data_oe && $past(sel_any && upper_byte_select) |-> data[7:4] == 4'h0 && data[3:0] == data[11:8];
  endproperty
  property p_latch_hold;
    $past(sel_lo) && $past(sel_lo, 2) && !busy_n |-> $stable(data);
  endproperty

  a_start_busy: assert property (p_start_busy) else $error("no busy after start");
  a_hi_nostart: assert property (p_hi_nostart) else $error("upper read started");
  a_busy_len: assert property (p_busy_len) else $error("busy too short");
  a_hi_read: assert property (p_hi_read) else $error("upper read stalled");
  a_oe_on: assert property (p_oe_on) else $error("data not driven");
  a_oe_off: assert property (p_oe_off) else $error("data driven idle");
  a_idle_zero: assert property (p_idle_zero) else $error("idle data not zero");
  a_hi_lanes: assert property (p_hi_lanes) else $error("upper lanes wrong");
  a_latch_hold: assert property (p_latch_hold) else $error("data moved in busy");
endmodule

// *** verification/testbench.sv ***
// self-checking bench joining both ends of the host read port
`timescale 1ns/100ps

module testbench;
  import ahrp_pkg::*;
  localparam int CONV = 20;
  logic         clock_in;
  logic         rst_in;
  logic         start_in;
  logic         wait_mode_in;
  logic         result_ready_in;
  logic         sample_valid_in;
  ahrp_sample_t sample_in;
  ahrp_sample_t result_out;
  logic         result_valid_out;
  logic         idle_out;
  logic         sample_ready_out;
  logic         conv_start_out;
  logic         conv_busy_out;
  int           num_errors;
  int           checks;
  int           cycles;
  int           starts;

  ahrp_if bus ();

  ahrp_device #(.CONV_CYC(CONV)) u_ahrp_device (
    .clock_in(clock_in), .rst_in(rst_in), .bus(bus),
    .sample_in(sample_in), .sample_valid_in(sample_valid_in),
    .sample_ready_out(sample_ready_out), .conv_start_out(conv_start_out),
    .conv_busy_out(conv_busy_out));

  ahrp_host #(.CONV_CYC(CONV)) u_ahrp_host (
    .clock_in(clock_in), .rst_in(rst_in), .bus(bus), .start_in(start_in),
    .wait_mode_in(wait_mode_in), .result_ready_in(result_ready_in),
    .result_out(result_out), .result_valid_out(result_valid_out), .idle_out(idle_out));

  ahrp_chk #(.CONV_CYC(CONV)) u_ahrp_chk (
    .clock_in(clock_in), .rst_in(rst_in), .cs_n(bus.cs_n), .rd_n(bus.rd_n),
    .upper_byte_select(bus.upper_byte_select), .busy_n(bus.busy_n),
    .data(bus.data), .data_oe(bus.data_oe));

  // free running clock
  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end

  // hang guard and external channel counter
  always @(posedge clock_in) begin
    cycles++;
    if (conv_start_out === 1'b1) starts++;
    if (cycles == 20000) begin
      num_errors++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // n edges, then settle past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask

  // valid is left high so back-to-back pushes never toggle it; caller lowers it
  task automatic push(input ahrp_sample_t s);
    sample_in = s;
    sample_valid_in = 1'b1;
    while (sample_ready_out !== 1'b1) tick(1);
    tick(1);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (idle_out !== 1'b1 && n < 10 * CONV) begin
      tick(1);
      n++;
    end
  endtask

  // one host sequence, result held back for stall cycles
  task automatic read(input logic mode, input ahrp_sample_t exp, input int stall);
    int n;
    n = 0;
    wait_idle();
    start_in = 1'b1;
    wait_mode_in = mode;
    tick(1);
    start_in = 1'b0;
    while (result_valid_out !== 1'b1 && n < 10 * CONV) begin
      tick(1);
      n++;
    end
    check("result", result_out, exp);
    tick(stall);
    check("held", result_out, exp);
    check("valid", 12'(result_valid_out), 12'h001);
    result_ready_in = 1'b1;
    tick(1);
    result_ready_in = 1'b0;
  endtask

  initial begin
    num_errors = 0;
    checks = 0;
    cycles = 0;
    starts = 0;
    rst_in = 1'b1;
    start_in = 1'b0;
    wait_mode_in = 1'b0;
    result_ready_in = 1'b0;
    sample_valid_in = 1'b0;
    sample_in = 12'h000;
    tick(4);
    rst_in = 1'b0;
    tick(1);
    check("ready", 12'(sample_ready_out), 12'h001);
    push(12'h5a3);
    push(12'hc3e);
    sample_in = 12'h777;
    sample_valid_in = 1'b1;
    tick(3);
    check("full", 12'(sample_ready_out), 12'h000);
    sample_valid_in = 1'b0;
    read(1'b1, 12'h5a3, 1);
    read(1'b0, 12'h5a3, 6);
    read(1'b0, 12'hc3e, 1);
    tick(2 * CONV);
    check("busy", 12'(conv_busy_out), 12'h001);
    push(12'h0f1);
    push(12'h2d8);
    sample_valid_in = 1'b0;
    read(1'b1, 12'h2d8, 1);
    wait_idle();
    check("idle", 12'(idle_out), 12'h001);
    check("starts", 12'(starts), 12'h004);
    complete_run();
  end
endmodule
